// ### src/alu_defines.svh
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH

// register byte addresses
`define ADDR_CTRL      12'h000
`define ADDR_OPERANDS  12'h004
`define ADDR_ACC       12'h008
`define ADDR_RESULT    12'h00c
`define ADDR_STATUS    12'h010
`define ADDR_DIR       12'h014

// control fields
`define CTRL_GO_BIT    0
`define CTRL_OP_LSB    4
`define CTRL_DEST_BIT  8

// operands fields
`define OPND_LIT_LSB   0
`define OPND_REG_LSB   8
`define OPND_SEL_LSB   16

// status bit positions
`define ST_CARRY       0
`define ST_NIBBLE      1
`define ST_ZERO        2
`define ST_PWR_DOWN    3
`define ST_EXPIRY      4
`define ST_HALT        5

// direction select operands
`define SEL_PORT_A     3'h5
`define SEL_PORT_B     3'h6
`define SEL_PORT_C     3'h7

// reset values
`define RST_STATUS     6'h18
`define RST_DIR        8'hff

`endif

// ### src/alu_pkg.sv
package alu_pkg;

  typedef enum logic [3:0] {
    rotate_right_carry_op   = 4'h0,
    literal_minus_acc_op    = 4'h1,
    reg_minus_acc_op        = 4'h2,
    reg_minus_acc_borrow_op = 4'h3,
    nibble_exchange_op      = 4'h4,
    literal_xor_acc_op      = 4'h5,
    reg_xor_acc_op          = 4'h6,
    sleep_op                = 4'h7,
    pin_direction_load_op   = 4'h8
  } alu_op_t;

  typedef struct packed {
    logic halt;
    logic watchdog_expiry_flag;
    logic power_down_flag;
    logic zero;
    logic nibble_borrow_flag;
    logic carry;
  } status_t;

  typedef struct packed {
    logic [7:0] port_c_direction_reg;
    logic [7:0] port_b_direction_reg;
    logic [7:0] port_a_direction_reg;
  } dir_regs_t;

endpackage : alu_pkg

// ### src/alu_core.sv
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "alu_defines.svh"
// Overview of operation
// - rotate right: old carry into bit 7, bit 0 into carry, only carry changes
// - destination bit 0 writes accumulator, 1 writes back the file register
// - literal minus accumulator, two's complement, result into accumulator
// - subtractions update carry, nibble and zero; carry is inverted borrow
// - nibble flag clear when accumulator low nibble exceeds other low nibble
// - file register minus accumulator, routed by destination bit
// - file register minus accumulator minus inverted carry, updates three flags
// - nibble exchange of file register, no flags change
// - accumulator xor literal into accumulator, zero flag only
// - accumulator xor file register, routed by destination bit, zero only
// - low-power entry clears watchdog and prescaler, sets expiry, clears power-down
// - after that status update execution halts and the oscillator stops
// - direction load copies accumulator to port a/b/c register for operand 5/6/7
//
// the block is a register-mapped execution unit: software stores an opcode,
// the operands and the destination bit, then writes go to execute once.
// the far register file reads the write-back value from the result register;
// the accumulator lives here so that chained operations need no reload.
// limitation: one operation per go write; the go write reuses the stored op.

module alu_core #(
  parameter int WATCHDOG_WIDTH = 8,
  parameter int PRE_WIDTH      = 8
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  wake,
  output logic                       osc_run,
  output alu_pkg::dir_regs_t         dir_out,
  output logic [WATCHDOG_WIDTH-1:0]  watchdog_counter,
  output logic [PRE_WIDTH-1:0]       watchdog_prescaler
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // counters wider than 24 bits would take longer to wrap than any use needs
  if (WATCHDOG_WIDTH < 1 || WATCHDOG_WIDTH > 24 || PRE_WIDTH < 1 || PRE_WIDTH > 24) begin : g_bad_width
    $error("watchdog widths must be 1..24");
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [3:0]             op_r;
  logic                   dest_r;
  logic [7:0]             lit_r;
  logic [7:0]             freg_r;
  logic [2:0]             sel_r;
  logic [7:0]             acc_r;
  logic [7:0]             result_r;
  alu_pkg::status_t       status_r;
  alu_pkg::dir_regs_t     dir_r;
  logic                   go;
  logic                   wake_s1_r;
  logic                   wake_s2_r;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data are caught separately so they may come in any order;
  // the write fires one cycle after the later of the two is taken.
  // both readies drop while a response waits, so at most one write is open.
  logic        aw_held_r;
  logic        w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_fire;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_fire       = aw_held_r && w_held_r;
  assign s_axi_bresp   = 2'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= 12'h000;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // an execute request is refused while halted; wake must come first
  assign go = wr_fire && awaddr_r == `ADDR_CTRL && wstrb_r[0]
              && wdata_r[`CTRL_GO_BIT] && !status_r.halt;

  // ----------------------------------------------------------------
  // operand registers
  // ----------------------------------------------------------------
  // op and dest update on the same fire that could carry go, so go always
  // sees the values stored by an earlier write, never the ones beside it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_r   <= 4'h0;
      dest_r <= 1'b0;
      lit_r  <= 8'h00;
      freg_r <= 8'h00;
      sel_r  <= 3'h0;
    end else if (wr_fire) begin
      if (awaddr_r == `ADDR_CTRL) begin
        if (wstrb_r[0]) op_r <= wdata_r[`CTRL_OP_LSB +: 4];
        if (wstrb_r[1]) dest_r <= wdata_r[`CTRL_DEST_BIT];
      end
      if (awaddr_r == `ADDR_OPERANDS) begin
        if (wstrb_r[0]) lit_r <= wdata_r[`OPND_LIT_LSB +: 8];
        if (wstrb_r[1]) freg_r <= wdata_r[`OPND_REG_LSB +: 8];
        if (wstrb_r[2]) sel_r <= wdata_r[`OPND_SEL_LSB +: 3];
      end
    end
  end

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  // one nine-bit subtractor serves all three subtraction forms; bit 8 is the
  // borrow, so carry is its inverse. the nibble subtractor mirrors it on the
  // low four bits, incoming borrow included, to give the nibble flag.
  logic [8:0]       diff;
  logic [4:0]       ndiff;
  logic [7:0]       minuend;
  logic             borrow_in;
  logic [7:0]       res;
  logic             to_acc;
  logic             to_freg;
  alu_pkg::status_t st_nxt;

  always_comb begin
    minuend   = freg_r;
    borrow_in = 1'b0;
    res       = 8'h00;
    to_acc    = 1'b0;
    to_freg   = 1'b0;
    st_nxt    = status_r;
    if (op_r == 4'(alu_pkg::literal_minus_acc_op)) begin
      minuend = lit_r;
    end
    if (op_r == 4'(alu_pkg::reg_minus_acc_borrow_op)) begin
      borrow_in = !status_r.carry;
    end
    diff  = {1'b0, minuend} - {1'b0, acc_r} - {8'h00, borrow_in};
    ndiff = {1'b0, minuend[3:0]} - {1'b0, acc_r[3:0]} - {4'h0, borrow_in};
    unique case (op_r)
      4'(alu_pkg::rotate_right_carry_op): begin
        res          = {status_r.carry, freg_r[7:1]};
        st_nxt.carry = freg_r[0];
      end
      4'(alu_pkg::literal_minus_acc_op),
      4'(alu_pkg::reg_minus_acc_op),
      4'(alu_pkg::reg_minus_acc_borrow_op): begin
        res                       = diff[7:0];
        st_nxt.carry              = !diff[8];
        st_nxt.nibble_borrow_flag = !ndiff[4];
        st_nxt.zero               = diff[7:0] == 8'h00;
      end
      4'(alu_pkg::nibble_exchange_op): begin
        res = {freg_r[3:0], freg_r[7:4]};
      end
      4'(alu_pkg::literal_xor_acc_op): begin
        res         = acc_r ^ lit_r;
        st_nxt.zero = res == 8'h00;
      end
      4'(alu_pkg::reg_xor_acc_op): begin
        res         = acc_r ^ freg_r;
        st_nxt.zero = res == 8'h00;
      end
      4'(alu_pkg::sleep_op): begin
        st_nxt.watchdog_expiry_flag = 1'b1;
        st_nxt.power_down_flag      = 1'b0;
        st_nxt.halt                 = 1'b1;
      end
      default: begin
        res = acc_r;
      end
    endcase
    // literal forms always land in the accumulator
    unique case (op_r)
      4'(alu_pkg::literal_minus_acc_op),
      4'(alu_pkg::literal_xor_acc_op): begin
        to_acc = 1'b1;
      end
      4'(alu_pkg::rotate_right_carry_op),
      4'(alu_pkg::reg_minus_acc_op),
      4'(alu_pkg::reg_minus_acc_borrow_op),
      4'(alu_pkg::nibble_exchange_op),
      4'(alu_pkg::reg_xor_acc_op): begin
        to_acc  = !dest_r;
        to_freg = dest_r;
      end
      default: begin
        // sleep and direction load write neither destination
        to_acc  = 1'b0;
        to_freg = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // results, flags, direction registers
  // ----------------------------------------------------------------
  // a software load of the accumulator takes priority; it cannot coincide
  // with go because both need their own write fire
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_r    <= 8'h00;
      result_r <= 8'h00;
    end else if (wr_fire && awaddr_r == `ADDR_ACC && wstrb_r[0]) begin
      acc_r <= wdata_r[7:0];
    end else if (go) begin
      if (to_acc) acc_r <= res;
      // write-back value for the far register file
      if (to_freg) result_r <= res;
    end
  end

  // go is refused while halted, so the sleep that sets halt and the wake that
  // clears it can never fall in one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_r <= alu_pkg::status_t'(`RST_STATUS);
    end else if (go) begin
      status_r <= st_nxt;
    end else if (wake_s2_r && status_r.halt) begin
      status_r.halt <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dir_r <= {3{`RST_DIR}};
    end else if (go && op_r == 4'(alu_pkg::pin_direction_load_op)) begin
      unique case (sel_r)
        `SEL_PORT_A: dir_r.port_a_direction_reg <= acc_r;
        `SEL_PORT_B: dir_r.port_b_direction_reg <= acc_r;
        `SEL_PORT_C: dir_r.port_c_direction_reg <= acc_r;
        default:     dir_r <= dir_r;
      endcase
    end
  end

  // watchdog: counts while running; cleared on low-power entry
  // the counter stands still while halted, as the oscillator it runs from
  // is stopped; it wraps silently, as no time-out action lives here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      watchdog_counter   <= '0;
      watchdog_prescaler <= '0;
    end else if (go && op_r == 4'(alu_pkg::sleep_op)) begin
      watchdog_counter   <= '0;
      watchdog_prescaler <= '0;
    end else if (!status_r.halt) begin
      watchdog_prescaler <= watchdog_prescaler + 1'b1;
      if (&watchdog_prescaler) watchdog_counter <= watchdog_counter + 1'b1;
    end
  end

  // wake is asynchronous; only the second flop feeds the halt logic

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end else begin
      wake_s1_r <= wake;
      wake_s2_r <= wake_s1_r;
    end
  end

  assign osc_run = !status_r.halt;
  assign dir_out = dir_r;

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  // read data is registered on the address handshake and held with rvalid;
  // go reads back as 0 because it is a strobe, not a stored bit
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp   = 2'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      unique case (s_axi_araddr)
        `ADDR_CTRL:     s_axi_rdata <= {23'h0, dest_r, op_r, 4'h0};
        `ADDR_OPERANDS: s_axi_rdata <= {13'h0, sel_r, freg_r, lit_r};
        `ADDR_ACC:      s_axi_rdata <= {24'h0, acc_r};
        `ADDR_RESULT:   s_axi_rdata <= {24'h0, result_r};
        `ADDR_STATUS:   s_axi_rdata <= {26'h0, status_r};
        `ADDR_DIR:      s_axi_rdata <= {8'h0, dir_r};
        default:        s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : alu_core

// ### tb/alu_core_properties.sv
`timescale 1ns/1ps
module alu_core_properties #(
  parameter int WATCHDOG_WIDTH = 8,
  parameter int PRE_WIDTH      = 8
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic                 osc_run,
  input wire alu_pkg::dir_regs_t   dir_out,
  input wire logic [WATCHDOG_WIDTH-1:0] watchdog_counter,
  input wire logic [PRE_WIDTH-1:0] watchdog_prescaler
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_sleep_clears: assert property (!osc_run |-> watchdog_counter == '0 && watchdog_prescaler == '0)
    else $error("counters not clear while halted");
  a_dir_on_write: assert property (!$stable(dir_out) |-> ##[0:1] s_axi_bvalid)
    else $error("direction changed without a write");
endmodule : alu_core_properties

bind alu_core alu_core_properties #(.WATCHDOG_WIDTH(WATCHDOG_WIDTH), .PRE_WIDTH(PRE_WIDTH))
  u_props (.*);

// ### tb/decoder_model.sv
`timescale 1ns/1ps
// --------
// bus master standing in for the decoder and register file
// --------
module decoder_model (
  input wire logic    clk,
  output logic [11:0] s_axi_awaddr,
  output logic        s_axi_awvalid,
  input wire logic    s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic        s_axi_wvalid,
  input wire logic    s_axi_wready,
  input wire logic    s_axi_bvalid,
  output logic        s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic        s_axi_arvalid,
  input wire logic    s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic    s_axi_rvalid,
  output logic        s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic p;
    logic q;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    p = 1'b1;
    q = 1'b1;
    while (p || q) begin
      @(posedge clk);
      if (p && s_axi_awready) begin
        p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      // released data is scrambled so a stale value is never mistaken for a fresh one
      if (q && s_axi_wready) begin
        q = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    while (!s_axi_bvalid) @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : decoder_model

// ### tb/mcu_alu_rotate_sub_xor_ops_bench.sv
`timescale 1ns/1ps
module mcu_alu_rotate_sub_xor_ops_bench;
  logic clk, rst_n, wake, osc_run;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  alu_pkg::dir_regs_t dir_out;
  logic [7:0] watchdog_counter, watchdog_prescaler;
  int fail_count, check_count;
  logic [2:0] fl, hi;
  logic [23:0] dm;
  alu_core i_alu_core (.*, .s_axi_wstrb(4'hf), .s_axi_bresp(), .s_axi_rresp());
  decoder_model i_decoder_model (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // --------
  // expectation and checking helpers
  // --------
  function automatic logic [10:0] calc(input logic [3:0] op, input logic [7:0] a, k, f,
                                       input logic [2:0] fi);
    logic [8:0] d;
    logic [4:0] n;
    logic [7:0] x, r;
    logic [2:0] fo;
    logic b;
    fo = fi;
    x = (op == 4'h1 || op == 4'h5) ? k : f;
    b = (op == 4'h3) ? !fi[0] : 1'b0;
    d = {1'b0, x} - {1'b0, a} - b;
    n = {1'b0, x[3:0]} - {1'b0, a[3:0]} - b;
    case (op)
      4'h0: {r, fo[0]} = {fi[0], f};
      4'h1, 4'h2, 4'h3: begin
        r = d[7:0];
        fo = {r == 8'h00, !n[4], !d[8]};
      end
      4'h4: r = {f[3:0], f[7:4]};
      default: begin
        r = a ^ x;
        fo[2] = r == 8'h00;
      end
    endcase
    return {fo, r};
  endfunction : calc
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    i_decoder_model.rd(a, v);
    chk(v, e);
  endtask : rchk
  // op is stored first, then go is written with the same op
  task automatic run(input logic [3:0] op, input logic d, input logic [7:0] k, f,
                     input logic [2:0] s);
    i_decoder_model.wr(12'h004, {13'h0, s, f, k});
    i_decoder_model.wr(12'h000, {23'h0, d, op, 4'h0});
    i_decoder_model.wr(12'h000, {23'h0, d, op, 4'h1});
  endtask : run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // --------
  // tests
  // --------
  initial begin
    logic [10:0] e;
    logic [7:0] a, k, f;
    logic [3:0] op;
    logic d, lw;
    rst_n = 1'b0;
    wake = 1'b0;
    fail_count = 0;
    check_count = 0;
    fl = 3'h0;
    hi = 3'h3;
    dm = 24'hffffff;
    void'($urandom(32'hc4225ba5));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(12'h014, {8'h0, dm});
    i_decoder_model.wr(12'h100, 32'h5a);
    i_decoder_model.wr(12'h010, 32'h0);
    rchk(12'h100, 32'h0);
    rchk(12'h010, {26'h0, hi, fl});
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      op = (i < 7) ? i[3:0] : 4'($urandom_range(6, 0));
      {a, k, f, d} = (i < 7) ? {8'h01, 8'h01, 8'h01, 1'b1} : 25'($urandom);
      i_decoder_model.wr(12'h008, {24'h0, a});
      run(op, d, k, f, 3'h0);
      e = calc(op, a, k, f, fl);
      fl = e[10:8];
      lw = op == 4'h1 || op == 4'h5 || !d;
      rchk(12'h008, {24'h0, lw ? e[7:0] : a});
      if (!lw) rchk(12'h00c, {24'h0, e[7:0]});
      rchk(12'h010, {26'h0, hi, fl});
    end
    $display("test ops done");
    for (int s = 4; s < 8; s++) begin
      a = 8'($urandom);
      i_decoder_model.wr(12'h008, {24'h0, a});
      run(4'h8, 1'b0, 8'h00, 8'h00, s[2:0]);
      if (s > 4) dm[(s - 5) * 8 +: 8] = a;
      chk({8'h0, dir_out}, {8'h0, dm});
      rchk(12'h014, {8'h0, dm});
      rchk(12'h010, {26'h0, hi, fl});
    end
    $display("test direction done");
    run(4'h7, 1'b0, 8'h00, 8'h00, 3'h0);
    hi = 3'h6;
    chk({31'h0, osc_run}, 32'h0);
    chk({24'h0, watchdog_counter | watchdog_prescaler}, 32'h0);
    rchk(12'h010, {26'h0, hi, fl});
    run(4'h5, 1'b0, 8'hff, 8'h00, 3'h0);
    rchk(12'h008, {24'h0, a});
    wake <= 1'b1;
    for (int t = 0; t < 8 && !osc_run; t++) @(posedge clk);
    wake <= 1'b0;
    hi = 3'h2;
    chk({31'h0, osc_run}, 32'h1);
    rchk(12'h010, {26'h0, hi, fl});
    $display("test sleep done");
    report_and_stop();
  end
  // the whole run needs under two thousand cycles; this leaves ample margin
  initial begin
    #200000;
    fail_count++;
    $display("BAD %0t timeout", $time);
    report_and_stop();
  end
endmodule : mcu_alu_rotate_sub_xor_ops_bench
